// *** hw/dee_pkg.sv ***
// package: register map, control bit layout, reset values and timing constants
package dee_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] DEE_DATA_OFS    = 8'h08;
    localparam logic [7:0] DEE_ADDR_OFS    = 8'h09;
    localparam logic [7:0] DEE_CONTROL_OFS = 8'h88;
    localparam logic [7:0] DEE_UNLOCK_OFS  = 8'h89;

    // ------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------
    localparam int DEE_RD_BIT   = 0;
    localparam int DEE_WR_BIT   = 1;
    localparam int DEE_WRITE_ENABLE_BIT_BIT = 2;
    localparam int DEE_ERR_BIT  = 3;
    localparam int DEE_DONE_BIT = 4;

    // ------------------------------------------------------------
    // values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] DEE_UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] DEE_UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] DEE_ZERO_BYTE   = 8'h00;
    localparam int         DEE_DEPTH       = 64;
    localparam logic [7:0] DEE_LAST_ADDR   = 8'h3F;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint DEE_CLK_HZ       = 200000000;
    localparam longint DEE_WRITE_MS     = 10;
    localparam longint DEE_PWRUP_MS     = 72;
    localparam longint DEE_WRITE_CYCLES = DEE_CLK_HZ * DEE_WRITE_MS / 1000;
    localparam longint DEE_PWRUP_CYCLES = DEE_CLK_HZ * DEE_PWRUP_MS / 1000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEE_UL_IDLE,
        DEE_UL_GOT55,
        DEE_UL_ARMED
    } dee_unlock_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dee_sfr_req_s;

endpackage : dee_pkg

// *** hw/dee_ctrl.sv ***
// data eeprom access controller: sfr registers, unlock, timed byte write
`timescale 1ns/10ps
// Contract
// - control register bits 7:5 absent and read zero
// - software can only set read and write start bits; hardware clears them
// - read start puts addressed byte in data register next cycle
// - read byte held in data register until next read or software write
// - write starts only after 55h then AAh to unlock then start
// - write start bit refused unless write enable already set
// - started write finishes even if write enable cleared
// - write enable cleared at power-up only, never automatically
// - write completion clears write start and sets sticky done flag
// - master clear or watchdog reset mid-write sets error flag, keeps address/data
// - unlock location stores nothing and reads as zero
// - internal timer of about 10 ms times each write
// - writes blocked while 72 ms power-up timer runs
// - code protection does not block or scramble cpu access
// - 64 byte array, addresses 0h to 3Fh
// - byte write erases then programs the location, no erase command
module dee_ctrl
    import dee_pkg::*;
#(
    parameter longint WRITE_CYCLES = DEE_WRITE_CYCLES,
    parameter longint PWRUP_CYCLES = DEE_PWRUP_CYCLES
)(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         por_n,
    input  wire logic         code_protect,
    input  wire dee_sfr_req_s sfr_req,
    output logic [7:0]        sfr_rdata,
    output logic              write_busy,
    output logic              write_done_irq
);

    // ------------------------------------------------------------
    // reset classification
    // ------------------------------------------------------------
    // rst_n covers every reset; por_n is power-on only. a rst_n without
    // por_n is a master clear or watchdog reset. both asynchronous.
    logic              wr_live_r;       // survives warm reset
    logic              err_r;
    logic              write_enable_bit_r;
    logic              pwrup_busy_r;
    logic [31:0]       pwrup_cnt_r;

    // ------------------------------------------------------------
    // storage and sfr state
    // ------------------------------------------------------------
    logic [7:0]        mem_r [DEE_DEPTH];
    logic [7:0]        data_r;
    logic [7:0]        addr_r;
    logic              wr_r;
    logic              done_r;
    dee_unlock_e       ul_r;
    dee_unlock_e       ul_nxt;
    logic [31:0]       wcnt_r;
    logic [5:0]        wr_addr_r;
    logic [7:0]        wr_data_r;

    wire logic         hit_data   = sfr_req.addr == DEE_DATA_OFS;
    wire logic         hit_addr   = sfr_req.addr == DEE_ADDR_OFS;
    wire logic         hit_ctrl   = sfr_req.addr == DEE_CONTROL_OFS;
    wire logic         hit_unlock = sfr_req.addr == DEE_UNLOCK_OFS;
    wire logic         any_acc    = sfr_req.wr | sfr_req.rd;
    wire logic         ctrl_wr    = sfr_req.wr & hit_ctrl;
    wire logic         set_rd     = ctrl_wr & sfr_req.wdata[DEE_RD_BIT];
    wire logic         new_write_enable_bit   = ctrl_wr ? sfr_req.wdata[DEE_WRITE_ENABLE_BIT_BIT] : write_enable_bit_r;
    // code_protect is deliberately not in any term here
    wire logic         start_ok   = ctrl_wr & sfr_req.wdata[DEE_WR_BIT]
                                  & write_enable_bit_r
                                  & (ul_r == DEE_UL_ARMED)
                                  & ~pwrup_busy_r
                                  & ~wr_r;
    wire logic         wdone      = wr_r & (wcnt_r == 32'(WRITE_CYCLES - 1));
    // address bits 7:6 ignored: 40h and up alias onto the 64 bytes
    wire logic [5:0]   rd_idx     = addr_r[5:0];

    // ------------------------------------------------------------
    // unlock detector
    // ------------------------------------------------------------
    always_comb
    begin
        ul_nxt = ul_r;
        if (any_acc)
        begin
            ul_nxt = DEE_UL_IDLE;
            if (sfr_req.wr & hit_unlock & (sfr_req.wdata == DEE_UNLOCK_KEY1))
                ul_nxt = DEE_UL_GOT55;
            else if (sfr_req.wr & hit_unlock & (sfr_req.wdata == DEE_UNLOCK_KEY2)
                     & (ul_r == DEE_UL_GOT55))
                ul_nxt = DEE_UL_ARMED;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ul_r <= DEE_UL_IDLE;
        else
            ul_r <= ul_nxt;
    end

    // ------------------------------------------------------------
    // power-on domain: power-up timer, write enable, error flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            pwrup_cnt_r  <= '0;
            pwrup_busy_r <= 1'b1;
            write_enable_bit_r       <= 1'b0;
            err_r        <= 1'b0;
        end
        else
        begin
            if (pwrup_busy_r)
                pwrup_cnt_r <= pwrup_cnt_r + 32'd1;
            if (pwrup_cnt_r == 32'(PWRUP_CYCLES - 1))
                pwrup_busy_r <= 1'b0;
            // survives warm resets; only power-on or a software control write clears it
            write_enable_bit_r     <= new_write_enable_bit;
            // warm reset is seen on clock edges only: a pulse between edges sets no error
            if (!rst_n && wr_live_r)
                err_r <= 1'b1;
            else if (ctrl_wr)
                err_r <= sfr_req.wdata[DEE_ERR_BIT];
        end
    end

    // marks a write in flight; frozen while rst_n is low so the error flag sees it,
    // then dropped at the first edge after a warm reset has killed the write
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            wr_live_r <= 1'b0;
        else if (rst_n)
            wr_live_r <= start_ok | (wr_r & ~wdone);
    end

    // ------------------------------------------------------------
    // write engine and control flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r   <= 1'b0;
            done_r <= 1'b0;
            wcnt_r <= '0;
        end
        else
        begin
            if (start_ok)
            begin
                wr_r   <= 1'b1;
                wcnt_r <= '0;
            end
            else if (wdone)
                wr_r <= 1'b0;
            else if (wr_r)
                wcnt_r <= wcnt_r + 32'd1;
            // set wins over a software clear in the same cycle
            if (wdone)
                done_r <= 1'b1;
            else if (ctrl_wr)
                done_r <= sfr_req.wdata[DEE_DONE_BIT];
        end
    end

    // latched copies keep the programmed byte stable mid-write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end
        else if (start_ok)
        begin
            wr_addr_r <= addr_r[5:0];
            wr_data_r <= data_r;
        end
    end

    // whole byte replaced: erase and program are one step here
    always_ff @(posedge clk)
    begin
        if (wdone)
            mem_r[wr_addr_r] <= wr_data_r;
    end

    // ------------------------------------------------------------
    // address and data registers
    // ------------------------------------------------------------
    // power-on reset only: contents survive warm resets so a broken write can be retried
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            addr_r <= DEE_ZERO_BYTE;
            data_r <= DEE_ZERO_BYTE;
        end
        else
        begin
            if (sfr_req.wr & hit_addr)
                addr_r <= sfr_req.wdata;
            if (sfr_req.wr & hit_data)
                data_r <= sfr_req.wdata;
            else if (set_rd)
                data_r <= mem_r[rd_idx];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // read start never holds: it completes in the cycle it is set
    wire logic [7:0] ctrl_view = {3'b000, done_r, err_r, write_enable_bit_r, wr_r, 1'b0};
    wire logic [7:0] rd_mux    = hit_data ? data_r :
                                 hit_addr ? addr_r :
                                 hit_ctrl ? ctrl_view :
                                 DEE_ZERO_BYTE;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= '0;
        else
            sfr_rdata <= rd_mux;
    end

    assign write_busy     = wr_r;
    assign write_done_irq = done_r;

    // ------------------------------------------------------------
    // assertion helpers
    // ------------------------------------------------------------
    // counts each write on its own, so the timer compare is checked independently
    logic [31:0]       chk_len_r;
    logic [31:0]       chk_pwr_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            chk_len_r <= '0;
        else if (start_ok)
            chk_len_r <= '0;
        else if (wr_r)
            chk_len_r <= chk_len_r + 32'd1;
    end

    // saturates so a long run cannot wrap it back into the window
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            chk_pwr_r <= '0;
        else if (chk_pwr_r != 32'hFFFF_FFFF)
            chk_pwr_r <= chk_pwr_r + 32'd1;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ctrl_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_req.rd & hit_ctrl) |=> (sfr_rdata[7:5] == 3'b000))
        else $error("control upper bits not zero");
    a_unlock_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_req.rd & hit_unlock) |=> (sfr_rdata == 8'h00))
        else $error("unlock location read nonzero");
    a_no_sw_wr_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_r & ~wdone) |=> wr_r)
        else $error("write start bit dropped early");
    a_write_enable_bit_gates_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(wr_r) |-> $past(write_enable_bit_r))
        else $error("write began without enable");
    a_unlock_needed: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(wr_r) |-> ($past(ul_r) == DEE_UL_ARMED))
        else $error("write began without unlock");
    a_pwrup_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        pwrup_busy_r |=> ~$rose(wr_r))
        else $error("write during power-up timer");
    a_done_on_finish: assert property (@(posedge clk) disable iff (!rst_n)
        wdone |=> (~wr_r & done_r))
        else $error("completion did not set done");
    a_read_next_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        (set_rd & ~(sfr_req.wr & hit_data)) |=> (data_r == mem_r[$past(rd_idx)]))
        else $error("read data not loaded");
    a_latch_stable: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_r & ~start_ok) |=> $stable(wr_addr_r) && $stable(wr_data_r))
        else $error("write latch changed mid-write");
    a_write_enable_bit_kept: assert property (@(posedge clk) disable iff (!por_n)
        (write_enable_bit_r & ~ctrl_wr) |=> write_enable_bit_r)
        else $error("write enable cleared by hardware");
    a_err_on_break: assert property (@(posedge clk) disable iff (!por_n)
        (~rst_n & wr_live_r) |=> err_r)
        else $error("interrupted write left no error flag");
    a_err_cause: assert property (@(posedge clk) disable iff (!por_n)
        $rose(err_r) |-> ((!$past(rst_n) && $past(wr_live_r)) || $past(ctrl_wr)))
        else $error("error flag set without cause");
    a_regs_kept: assert property (@(posedge clk) disable iff (!por_n)
        (~rst_n & ~sfr_req.wr) |=> ($stable(addr_r) && $stable(data_r)))
        else $error("address or data lost in warm reset");
    a_data_held: assert property (@(posedge clk) disable iff (!rst_n)
        (~(sfr_req.wr & hit_data) & ~set_rd) |=> $stable(data_r))
        else $error("read byte not held");
    a_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_req.rd & hit_ctrl) |=> (~sfr_rdata[DEE_RD_BIT] && sfr_rdata[DEE_DONE_BIT] == $past(done_r)
                                     && sfr_rdata[DEE_WR_BIT] == $past(wr_r)))
        else $error("control read does not show flags");
    a_unlock_resets: assert property (@(posedge clk) disable iff (!rst_n)
        (any_acc & ~(sfr_req.wr & hit_unlock)) |=> (ul_r == DEE_UL_IDLE))
        else $error("unlock detector not reset by other access");
    a_unlock_step2: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_req.wr & hit_unlock & (sfr_req.wdata == DEE_UNLOCK_KEY2) & (ul_r == DEE_UL_GOT55))
            |=> (ul_r == DEE_UL_ARMED))
        else $error("second key did not arm");
    a_unlock_no_store: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_req.wr & hit_unlock) |=> ($stable(addr_r) && $stable(data_r)))
        else $error("unlock write stored data");
    a_byte_programmed: assert property (@(posedge clk) disable iff (!rst_n)
        wdone |=> (mem_r[$past(wr_addr_r)] == $past(wr_data_r)))
        else $error("completed write did not program byte");
    a_done_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (done_r & ~ctrl_wr) |=> done_r)
        else $error("done flag cleared by hardware");
    a_busy_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_r & ~wdone & ctrl_wr & sfr_req.wdata[DEE_WR_BIT]) |=> (wcnt_r == $past(wcnt_r) + 32'd1))
        else $error("restart disturbed a write in progress");
    a_write_length: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(wr_r) |-> (chk_len_r == 32'(WRITE_CYCLES)))
        else $error("write cycle length wrong");
    a_pwrup_window: assert property (@(posedge clk) disable iff (!por_n)
        $fell(pwrup_busy_r) |-> (chk_pwr_r == 32'(PWRUP_CYCLES)))
        else $error("power-up timer length wrong");

    c_write_done: cover property (@(posedge clk) disable iff (!rst_n) wdone);
    c_read:       cover property (@(posedge clk) disable iff (!rst_n) set_rd);
    c_armed:      cover property (@(posedge clk) disable iff (!rst_n) ul_r == DEE_UL_ARMED);
    c_error:      cover property (@(posedge clk) disable iff (!por_n) $rose(err_r));
    c_protected:  cover property (@(posedge clk) disable iff (!rst_n) code_protect & wdone);

endmodule : dee_ctrl

// *** sim/dee_cpu_model.sv ***
// cpu-side partner: drives one special function register access per clock
`timescale 1ns/10ps
module dee_cpu_model
    import dee_pkg::*;
(
    input  wire logic   clk,
    output dee_sfr_req_s sfr_req
);
    initial sfr_req = '0;

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    endtask : w

    task automatic r(input logic [7:0] a);
        @(posedge clk);
        sfr_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    endtask : r

    task automatic idle();
        @(posedge clk);
        sfr_req <= '0;
    endtask : idle

    // address and byte go in before any unlock; top address bits stay clear
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        w(DEE_ADDR_OFS, {2'h0, a});
        w(DEE_DATA_OFS, d);
    endtask : put

    // unbroken run with no other access, as if interrupts were held off
    task automatic unlock_start();
        w(DEE_CONTROL_OFS, 8'h04);
        w(DEE_UNLOCK_OFS, DEE_UNLOCK_KEY1);
        w(DEE_UNLOCK_OFS, DEE_UNLOCK_KEY2);
        w(DEE_CONTROL_OFS, 8'h06);
        idle();
    endtask : unlock_start
endmodule : dee_cpu_model

// *** sim/test_data_eeprom_access_controller.sv ***
// self-checking bench for the data eeprom access controller
`timescale 1ns/10ps
module test_data_eeprom_access_controller import dee_pkg::*;;
    // ------------------------------------------------------------
    // short counts so a write fits in a few dozen cycles
    // ------------------------------------------------------------
    localparam longint WCYC = 20;
    localparam longint PCYC = 10;

    logic         clk          = 1'h0;
    logic         rst_n        = 1'h0;
    logic         por_n        = 1'h0;
    logic         code_protect = 1'h0;
    logic         rd_d         = 1'h0;
    logic [7:0]   sfr_rdata;
    logic         write_busy;
    logic         write_done_irq;
    dee_sfr_req_s sfr_req;
    int           errors       = 0;
    int           num_checks   = 0;
    int           cyc          = 0;
    int           seed         = 32'hA8427297;
    logic [7:0]   exp_q[$];
    logic [7:0]   mem_exp[64];

    always #2.5 clk = ~clk;

    dee_cpu_model u_dee_cpu_model (.clk(clk), .sfr_req(sfr_req));

    dee_ctrl #(.WRITE_CYCLES(WCYC), .PWRUP_CYCLES(PCYC)) u_dee_ctrl (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .code_protect(code_protect), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .write_busy(write_busy), .write_done_irq(write_done_irq));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // read data is registered: compare one edge after the strobe was taken
    always @(posedge clk)
    begin
        if (rd_d && exp_q.size() > 0)
            chk("sfr_rdata", exp_q.pop_front(), sfr_rdata);
        rd_d <= sfr_req.rd;
        cyc++;
        if (cyc > 3000)
        begin
            chk("cycle limit", 8'h00, 8'h01);
            end_sim();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_dee_cpu_model.r(a);
        u_dee_cpu_model.idle();
    endtask : rd

    task automatic wait_write(input int lo);
        int n;
        n = 0;
        #1;
        chk("write_busy", 8'(lo > 0), 8'(write_busy));
        while (write_busy === 1'h1 && n < 1000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (lo > 0)
            chk("write length in range", 8'h01, 8'(n >= lo && n <= WCYC + 1));
    endtask : wait_write

    task automatic ee_write(input logic [5:0] a, input logic [7:0] d);
        u_dee_cpu_model.put(a, d);
        u_dee_cpu_model.unlock_start();
        wait_write(WCYC - 1);
        mem_exp[a] = d;
        chk("write_done_irq", 8'h01, 8'(write_done_irq));
        rd(DEE_CONTROL_OFS, 8'h14);
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h04);
        u_dee_cpu_model.idle();
    endtask : ee_write

    task automatic ee_read(input logic [5:0] a);
        u_dee_cpu_model.w(DEE_ADDR_OFS, {2'h0, a});
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h05);
        rd(DEE_DATA_OFS, mem_exp[a]);
        rd(DEE_CONTROL_OFS, 8'h04);
        rd(DEE_DATA_OFS, mem_exp[a]);
    endtask : ee_read

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] bad[4][5];
        logic [5:0]  adr[4];
        logic [7:0]  d;
        bad = '{'{16'h8804, 16'h8955, 16'h0A00, 16'h89AA, 16'h8806},
                '{16'h8804, 16'h89AA, 16'h8955, 16'h8806, 16'h0A00},
                '{16'h8800, 16'h8955, 16'h89AA, 16'h8802, 16'h0A00},
                '{16'h8804, 16'h8955, 16'h89AA, 16'h0A00, 16'h8806}};
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        por_n <= 1'h1;
        rd(DEE_CONTROL_OFS, 8'h00);
        u_dee_cpu_model.put(6'h05, 8'h5A);
        u_dee_cpu_model.unlock_start();
        wait_write(0);
        repeat (PCYC) @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            for (int s = 0; s < 5; s++)
                u_dee_cpu_model.w(bad[k][s][15:8], bad[k][s][7:0]);
            u_dee_cpu_model.idle();
            wait_write(0);
            rd(DEE_CONTROL_OFS, (k == 2) ? 8'h00 : 8'h04);
        end
        adr = '{6'h00, 6'h3F, 6'($random(seed)), 6'h00};
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed));
            code_protect <= 1'(i);
            ee_write(adr[i], d);
            ee_read(adr[i]);
        end
        // restart attempts and enable clear while busy must not disturb the write
        u_dee_cpu_model.put(6'h21, 8'h96);
        u_dee_cpu_model.unlock_start();
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h00);
        u_dee_cpu_model.put(6'h00, ~mem_exp[0]);
        u_dee_cpu_model.unlock_start();
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h00);
        u_dee_cpu_model.idle();
        wait_write(1);
        mem_exp[6'h21] = 8'h96;
        rd(DEE_CONTROL_OFS, 8'h10);
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h04);
        ee_read(6'h21);
        ee_read(6'h00);
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'hFF);
        u_dee_cpu_model.idle();
        rd(DEE_CONTROL_OFS, 8'h1C);
        u_dee_cpu_model.w(DEE_CONTROL_OFS, 8'h00);
        u_dee_cpu_model.w(DEE_UNLOCK_OFS, 8'h5A);
        rd(DEE_CONTROL_OFS, 8'h00);
        rd(DEE_UNLOCK_OFS, 8'h00);
        rd(8'h0A, 8'h00);
        // warm reset in mid-write
        u_dee_cpu_model.put(6'h22, 8'hC3);
        u_dee_cpu_model.unlock_start();
        repeat (3) @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd(DEE_CONTROL_OFS, 8'h0C);
        rd(DEE_ADDR_OFS, 8'h22);
        rd(DEE_DATA_OFS, 8'hC3);
        repeat (3) @(posedge clk);
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        end_sim();
    end
endmodule : test_data_eeprom_access_controller
